// ==== hdl/urfe_pkg.sv ====
// package: register map, reset values and shared types of the uart front end
package urfe_pkg;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [2:0] OFS_BYTE_PORT = 3'h0;  // also divisor_low
   localparam logic [2:0] OFS_ENABLE    = 3'h1;  // also divisor_high
   localparam logic [2:0] OFS_IDENTIFY  = 3'h2;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_DIV_LOW   = 8'h01;
   localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
   localparam logic [3:0] RST_ENABLE    = 4'h0;
   localparam logic [7:0] RST_IDENTIFY  = 8'h01;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int EN_RX_READY    = 0;
   localparam int EN_TX_EMPTY    = 1;
   localparam int EN_LINE_ERROR  = 2;
   localparam int EN_MODEM       = 3;
   localparam int ID_NONE        = 0;
   localparam int ID_CODE_LO     = 1;
   localparam int ID_TIMEOUT     = 3;
   localparam int ID_QUEUE_LO    = 6;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int TICKS_PER_BIT  = 16;
   localparam int BITS_PER_CHAR  = 10;
   localparam int TIMEOUT_CHARS  = 4;
   localparam int TIMEOUT_TICKS  =
      TIMEOUT_CHARS * BITS_PER_CHAR * TICKS_PER_BIT;
   localparam int BAUD_CLK_MHZ_MAX = 24;
   localparam int DIVISOR_MIN    = 2;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      URFE_SRC_MODEM    = 2'b00,
      URFE_SRC_TX_EMPTY = 2'b01,
      URFE_SRC_RX_READY = 2'b10,
      URFE_SRC_LINE_ERR = 2'b11
   } urfe_src_t;

   typedef struct packed {
      logic lineErr;
      logic rxReady;
      logic timeout;
      logic txEmpty;
      logic modem;
   } urfe_pend_t;

endpackage

// ==== hdl/urfe_skid.sv ====
// file: two-entry buffer with registered output stage
`timescale 1ns/1ps
module urfe_skid #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output      logic             inReady,
   output      logic             outValid,
   output      logic [WIDTH-1:0] outData,
   input  wire logic             outReady
);

   logic             spareValid;
   logic [WIDTH-1:0] spareData;
   logic             push;
   logic             pop;

   assign push = inValid & inReady;
   assign pop  = outValid & outReady;

   // ***************************************************************
   // output stage
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         outValid <= 1'b0;
         outData  <= '0;
      end else if (!outValid || pop) begin
         // the spare entry is older than anything arriving now
         if (spareValid) begin
            outValid <= 1'b1;
            outData  <= spareData;
         end else begin
            outValid <= push;
            if (push) begin
               outData <= inData;
            end
         end
      end
   end

   // ***************************************************************
   // spare entry and ready flag
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         spareValid <= 1'b0;
         spareData  <= '0;
         inReady    <= 1'b1;
      end else begin
         if (push && outValid && !pop) begin
            spareValid <= 1'b1;
            spareData  <= inData;
            inReady    <= 1'b0;
         end else if (pop && spareValid) begin
            spareValid <= push;
            if (push) begin
               spareData <= inData;
            end
            inReady <= !push;
         end
      end
   end

endmodule

// ==== hdl/urfe_top.sv ====
// file: uart register front end - data port, divisor, enables, identify
`timescale 1ns/1ps
module urfe_top
   import urfe_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic [2:0] ioAddr,
   input  wire logic       ioRead,
   input  wire logic       ioWrite,
   input  wire logic [7:0] ioWdata,
   output      logic [7:0] ioRdata,
   input  wire logic       divisorSelect,
   input  wire logic       queueOnFlags,
   input  wire logic       lineErrEvent,
   input  wire logic       lineStatusRead,
   input  wire logic       modemEvent,
   input  wire logic       modemStatusRead,
   input  wire logic       rxBelowTrigger,
   input  wire logic       rxValid,
   input  wire logic [7:0] rxData,
   output      logic       rxReady,
   output      logic       txValid,
   output      logic [7:0] txData,
   input  wire logic       txReady,
   output      logic       txHoldFree,
   output      logic       baudTick16,
   output      logic       irqOut
);

   // ***************************************************************
   // access decode
   // ***************************************************************
   logic        readHeld;
   logic        readStart;
   logic        wrByte;
   logic        rdByte;
   logic        wrDivLow;
   logic        wrDivHigh;
   logic        wrEnable;
   logic        rdIdentify;

   // side effects happen once, on the first cycle of a read access
   assign readStart  = ioRead & !readHeld;
   assign wrByte     = ioWrite & !divisorSelect
                       & (ioAddr == OFS_BYTE_PORT);
   assign rdByte     = readStart & !divisorSelect
                       & (ioAddr == OFS_BYTE_PORT);
   assign wrDivLow   = ioWrite & divisorSelect
                       & (ioAddr == OFS_BYTE_PORT);
   assign wrDivHigh  = ioWrite & divisorSelect
                       & (ioAddr == OFS_ENABLE);
   assign wrEnable   = ioWrite & !divisorSelect
                       & (ioAddr == OFS_ENABLE);
   assign rdIdentify = readStart & (ioAddr == OFS_IDENTIFY);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         readHeld <= 1'b0;
      end else begin
         readHeld <= ioRead;
      end
   end

   // ***************************************************************
   // divisor latches and baud generator
   // ***************************************************************
   logic [7:0]  divLow;
   logic [7:0]  divHigh;
   logic [15:0] baudCount;
   logic [15:0] divisor;

   assign divisor = {divHigh, divLow};

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         divLow  <= RST_DIV_LOW;
         divHigh <= RST_DIV_HIGH;
      end else begin
         if (wrDivLow) begin
            divLow <= ioWdata;
         end
         if (wrDivHigh) begin
            divHigh <= ioWdata;
         end
      end
   end

   // one tick every divisor clocks, i.e. sixteen ticks per bit;
   // a divisor of zero wraps and gives 65536 clocks per tick
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         baudCount  <= {RST_DIV_HIGH, RST_DIV_LOW};
         baudTick16 <= 1'b0;
      end else if (wrDivLow) begin
         baudCount  <= {divHigh, ioWdata};
         baudTick16 <= 1'b0;
      end else if (wrDivHigh) begin
         baudCount  <= {ioWdata, divLow};
         baudTick16 <= 1'b0;
      end else if (baudCount == 16'h0001) begin
         baudCount  <= divisor;
         baudTick16 <= 1'b1;
      end else begin
         baudCount  <= baudCount - 16'h0001;
         baudTick16 <= 1'b0;
      end
   end

   // ***************************************************************
   // transmit holding path
   // ***************************************************************
   logic skidInReady;
   logic skidOutValid;
   logic txWasBusy;
   logic txNowEmpty;

   // a write while both entries are full is dropped; txHoldFree warns
   urfe_skid #(
      .WIDTH (8)
   ) txHold (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .inValid  (wrByte),
      .inData   (ioWdata),
      .inReady  (skidInReady),
      .outValid (skidOutValid),
      .outData  (txData),
      .outReady (txReady)
   );

   assign txValid    = skidOutValid;
   assign txHoldFree = skidInReady;
   assign txNowEmpty = txWasBusy & !skidOutValid;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         txWasBusy <= 1'b0;
      end else begin
         txWasBusy <= skidOutValid;
      end
   end

   // ***************************************************************
   // receive buffer and character timeout
   // ***************************************************************
   logic [7:0]  rxByte;
   logic        rxFull;
   logic        rxTake;
   logic [15:0] idleTicks;
   logic        timeoutHit;

   assign rxTake = rxValid & rxReady;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rxByte  <= 8'h00;
         rxFull  <= 1'b0;
         rxReady <= 1'b1;
      end else begin
         if (rxTake) begin
            rxByte  <= rxData;
            rxFull  <= 1'b1;
            rxReady <= 1'b0;
         end else if (rdByte) begin
            rxFull  <= 1'b0;
            rxReady <= 1'b1;
         end
      end
   end

   // counts baud ticks while a held byte sees no movement
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         idleTicks  <= 16'h0000;
         timeoutHit <= 1'b0;
      end else if (!rxFull || rxTake || rdByte) begin
         idleTicks  <= 16'h0000;
         timeoutHit <= 1'b0;
      end else if (baudTick16 && !timeoutHit) begin
         if (idleTicks == 16'(TIMEOUT_TICKS - 1)) begin
            timeoutHit <= 1'b1;
         end
         idleTicks <= idleTicks + 16'h0001;
      end
   end

   // ***************************************************************
   // pending sources
   // ***************************************************************
   urfe_pend_t pend;
   logic       lineErrFlag;
   logic       modemFlag;
   logic       txEmptyFlag;
   logic       rxTrigHold;
   logic [3:0] enables;
   logic       thrReported;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         lineErrFlag <= 1'b0;
         modemFlag   <= 1'b0;
      end else begin
         // a new event wins over a clear in the same cycle
         if (lineErrEvent) begin
            lineErrFlag <= 1'b1;
         end else if (lineStatusRead) begin
            lineErrFlag <= 1'b0;
         end
         if (modemEvent) begin
            modemFlag <= 1'b1;
         end else if (modemStatusRead) begin
            modemFlag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         txEmptyFlag <= 1'b0;
      end else if (txNowEmpty) begin
         txEmptyFlag <= 1'b1;
      end else if (wrByte || (rdIdentify && thrReported)) begin
         txEmptyFlag <= 1'b0;
      end
   end

   // in queue mode the receive logic may withdraw rx-ready early
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rxTrigHold <= 1'b0;
      end else if (rxTake || !rxFull) begin
         rxTrigHold <= 1'b0;
      end else if (rxBelowTrigger && queueOnFlags) begin
         rxTrigHold <= 1'b1;
      end
   end

   always_comb begin
      pend.lineErr = lineErrFlag & enables[EN_LINE_ERROR];
      pend.rxReady = rxFull & !rxTrigHold
                     & enables[EN_RX_READY];
      pend.timeout = timeoutHit & queueOnFlags
                     & enables[EN_RX_READY];
      pend.txEmpty = txEmptyFlag & enables[EN_TX_EMPTY];
      pend.modem   = modemFlag & enables[EN_MODEM];
   end

   // ***************************************************************
   // enable register
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         enables <= RST_ENABLE;
      end else if (wrEnable) begin
         enables <= ioWdata[3:0];
      end
   end

   // ***************************************************************
   // identify value
   // ***************************************************************
   logic [7:0] idLive;
   urfe_src_t  topSrc;
   logic       anyPend;

   assign anyPend = |pend;

   always_comb begin
      if (pend.lineErr) begin
         topSrc = URFE_SRC_LINE_ERR;
      end else if (pend.rxReady || pend.timeout) begin
         topSrc = URFE_SRC_RX_READY;
      end else if (pend.txEmpty) begin
         topSrc = URFE_SRC_TX_EMPTY;
      end else begin
         topSrc = URFE_SRC_MODEM;
      end
      idLive                  = 8'h00;
      idLive[ID_QUEUE_LO+1]   = queueOnFlags;
      idLive[ID_QUEUE_LO]     = queueOnFlags;
      idLive[ID_TIMEOUT]      = !pend.lineErr & !pend.rxReady
                                & pend.timeout;
      idLive[ID_CODE_LO+1]    = anyPend & topSrc[1];
      idLive[ID_CODE_LO]      = anyPend & topSrc[0];
      idLive[ID_NONE]         = !anyPend;
   end

   assign thrReported = anyPend & (topSrc == URFE_SRC_TX_EMPTY);

   // ***************************************************************
   // read data and interrupt output
   // ***************************************************************
   // read data is caught on the first cycle and held for the whole
   // access, so flags may change underneath without tearing the value
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ioRdata <= RST_IDENTIFY;
      end else if (readStart) begin
         unique case (ioAddr)
            OFS_BYTE_PORT: begin
               ioRdata <= divisorSelect ? divLow : rxByte;
            end
            OFS_ENABLE: begin
               ioRdata <= divisorSelect ? divHigh
                                        : {4'h0, enables};
            end
            OFS_IDENTIFY: begin
               ioRdata <= idLive;
            end
            default: begin
               ioRdata <= 8'h00;
            end
         endcase
      end else if (!ioRead) begin
         ioRdata <= 8'h00;
      end
   end

   // events during a held identify read still set flags above
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= anyPend;
      end
   end

endmodule

// ==== test/tb_top.sv ====
// testbench: register accesses, link traffic and interrupt sequences
`timescale 1ns/1ps
module tb_top;
   import urfe_pkg::*;
   logic       clk_sys, sys_rst, ioRead, ioWrite, divisorSelect;
   logic       queueOnFlags, rxValid, rxReady, txValid, txReady;
   logic       txHoldFree, baudTick16, irqOut, stall;
   logic [2:0] ioAddr;
   logic [7:0] ioWdata, ioRdata, rxData, txData;
   logic [4:0] evts;
   int         n_errors, checks_done, n;
   urfe_top uut (.clk_sys, .sys_rst, .ioAddr, .ioRead, .ioWrite, .ioWdata,
      .ioRdata, .divisorSelect, .queueOnFlags, .lineErrEvent(evts[0]),
      .lineStatusRead(evts[1]), .modemEvent(evts[2]),
      .modemStatusRead(evts[3]), .rxBelowTrigger(evts[4]), .rxValid,
      .rxData, .rxReady, .txValid, .txData, .txReady, .txHoldFree,
      .baudTick16, .irqOut);
   urfe_link_model mdl (.clk_sys, .sys_rst, .stall, .rxValid, .rxData,
      .rxReady, .txValid, .txData, .txReady);
   always #2.5 clk_sys = ~clk_sys;
   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic chk8(input string nm, input logic [7:0] e, logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkn(input string nm, input int e, input int g);
      checks_done++;
      if (g != e) begin
         n_errors++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      ioWrite = 1'b1;
      ioAddr  = a;
      ioWdata = d;
      @(negedge clk_sys);
      ioWrite = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, string nm);
      @(negedge clk_sys);
      ioRead = 1'b1;
      ioAddr = a;
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk8(nm, e, ioRdata);
      ioRead = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic pulse(input int k);
      @(negedge clk_sys);
      evts[k] = 1'b1;
      @(negedge clk_sys);
      evts[k] = 1'b0;
   endtask
   task automatic gap(output int c);
      c = 0;
      do begin
         @(negedge clk_sys);
         c++;
      end while (baudTick16 !== 1'b1 && c < 300);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ***************************************************************
   // sequence
   // ***************************************************************
   initial begin
      clk_sys = 1'b0; sys_rst = 1'b1; ioAddr = 3'h0; ioRead = 1'b0;
      ioWrite = 1'b0; ioWdata = 8'h00; divisorSelect = 1'b0;
      queueOnFlags = 1'b0; evts = 5'h00; stall = 1'b1;
      n_errors = 0; checks_done = 0;
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      rd(OFS_IDENTIFY, RST_IDENTIFY, "identify reset");
      rd(OFS_ENABLE, 8'h00, "enable reset");
      rd(3'h5, 8'h00, "unmapped offset");
      divisorSelect = 1'b1;
      rd(OFS_BYTE_PORT, RST_DIV_LOW, "divisor low reset");
      rd(OFS_ENABLE, RST_DIV_HIGH, "divisor high reset");
      wr(OFS_BYTE_PORT, 8'h04);
      wr(OFS_ENABLE, 8'h01);
      wr(OFS_ENABLE, 8'h00);
      gap(n);
      chkn("reload delay", 1, int'(n <= 5));
      gap(n);
      chkn("baud gap", 4, n);
      rd(OFS_BYTE_PORT, 8'h04, "divisor low");
      divisorSelect = 1'b0;
      rd(OFS_ENABLE, 8'h00, "enable untouched");
      // transmit: fill the hold buffer against a stalled sink
      wr(OFS_ENABLE, 8'h02);
      wr(OFS_BYTE_PORT, 8'ha0);
      wr(OFS_BYTE_PORT, 8'ha1);
      wr(OFS_BYTE_PORT, 8'ha2);
      chk8("hold free", 8'h00, {7'h0, txHoldFree});
      stall = 1'b0;
      repeat (8) @(negedge clk_sys);
      chkn("tx count", 2, mdl.txSeen.size());
      chk8("tx first", 8'ha0, mdl.txSeen[0]);
      chk8("tx second", 8'ha1, mdl.txSeen[1]);
      chk8("irq tx empty", 8'h01, {7'h0, irqOut});
      rd(OFS_IDENTIFY, 8'h02, "identify tx");
      chk8("irq after id read", 8'h00, {7'h0, irqOut});
      rd(OFS_IDENTIFY, 8'h01, "identify cleared");
      // priority, with an event landing inside an identify read
      mdl.offer(8'h5a);
      wr(OFS_ENABLE, 8'hff);
      pulse(2);
      fork
         rd(OFS_IDENTIFY, 8'h04, "identify frozen");
         // the line error lands on the edge that takes the read
         pulse(0);
      join
      rd(OFS_IDENTIFY, 8'h06, "identify line");
      rd(OFS_ENABLE, 8'h0f, "enable bits");
      pulse(1);
      rd(OFS_IDENTIFY, 8'h04, "identify rx");
      rd(OFS_BYTE_PORT, 8'h5a, "rx byte");
      rd(OFS_IDENTIFY, 8'h00, "identify modem");
      pulse(3);
      rd(OFS_IDENTIFY, 8'h01, "identify none");
      chk8("irq idle", 8'h00, {7'h0, irqOut});
      // disabled source stays hidden but recorded
      wr(OFS_ENABLE, 8'h00);
      pulse(2);
      repeat (3) @(negedge clk_sys);
      chk8("irq disabled", 8'h00, {7'h0, irqOut});
      rd(OFS_IDENTIFY, 8'h01, "identify disabled");
      wr(OFS_ENABLE, 8'h08);
      repeat (2) @(negedge clk_sys);
      chk8("irq late enable", 8'h01, {7'h0, irqOut});
      pulse(3);
      // queue mode and character timeout
      queueOnFlags = 1'b1;
      wr(OFS_ENABLE, 8'h01);
      rd(OFS_IDENTIFY, 8'hc1, "identify queue");
      mdl.offer(8'h3c);
      rd(OFS_IDENTIFY, 8'hc4, "identify queue rx");
      pulse(4);
      rd(OFS_IDENTIFY, 8'hc1, "identify below");
      repeat (TIMEOUT_TICKS * 4 + 40) @(negedge clk_sys);
      rd(OFS_IDENTIFY, 8'hcc, "identify timeout");
      rd(OFS_BYTE_PORT, 8'h3c, "rx queued byte");
      rd(OFS_IDENTIFY, 8'hc1, "identify drained");
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      tally_and_finish();
   end
endmodule
bind urfe_top urfe_top_properties chk (.clk_sys, .sys_rst, .ioAddr,
   .ioRead, .ioWrite, .ioWdata, .ioRdata, .divisorSelect, .queueOnFlags,
   .lineErrEvent, .rxValid, .rxReady, .txValid, .txData, .txReady,
   .txHoldFree, .baudTick16, .irqOut);

// ==== test/urfe_link_model.sv ====
// partner model: receive source offering whole bytes and transmit sink
`timescale 1ns/1ps
module urfe_link_model (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       stall,
   output      logic       rxValid,
   output      logic [7:0] rxData,
   input  wire logic       rxReady,
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   output      logic       txReady
);
   logic [7:0] txSeen[$];
   initial begin
      rxValid = 1'b0;
      rxData  = 8'h00;
      txReady = 1'b0;
   end
   // stall lets the bench hold the sink slow while the buffer fills
   always @(negedge clk_sys) txReady <= !stall && !sys_rst;
   always @(posedge clk_sys) begin
      if (!sys_rst && txValid && txReady) txSeen.push_back(txData);
   end
   task automatic offer(input logic [7:0] b);
      @(negedge clk_sys);
      rxValid = 1'b1;
      rxData  = b;
      while (rxReady !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      rxValid = 1'b0;
      rxData  = ~b;  // released line never repeats the last byte
   endtask
endmodule

// ==== test/urfe_top_properties.sv ====
// checker: port-level properties of the uart register front end
`timescale 1ns/1ps
module urfe_top_properties
   import urfe_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic [2:0] ioAddr,
   input wire logic       ioRead,
   input wire logic       ioWrite,
   input wire logic [7:0] ioWdata,
   input wire logic [7:0] ioRdata,
   input wire logic       divisorSelect,
   input wire logic       queueOnFlags,
   input wire logic       lineErrEvent,
   input wire logic       rxValid,
   input wire logic       rxReady,
   input wire logic       txValid,
   input wire logic [7:0] txData,
   input wire logic       txReady,
   input wire logic       txHoldFree,
   input wire logic       baudTick16,
   input wire logic       irqOut
);
   // ***************************************************************
   // shadow state
   // ***************************************************************
   logic [3:0]  enShadow;
   logic [15:0] divShadow;
   logic [16:0] gapCnt;
   logic        clean;
   logic        enWr;
   logic        divWr;
   logic        idRd;
   assign enWr  = ioWrite && !divisorSelect && ioAddr == OFS_ENABLE;
   assign divWr = ioWrite && divisorSelect && ioAddr <= OFS_ENABLE;
   assign idRd  = ioRead && ioAddr == OFS_IDENTIFY;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) enShadow <= RST_ENABLE;
      else if (enWr) enShadow <= ioWdata[3:0];
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) divShadow <= {RST_DIV_HIGH, RST_DIV_LOW};
      else if (divWr && ioAddr[0]) divShadow[15:8] <= ioWdata;
      else if (divWr) divShadow[7:0] <= ioWdata;
   end
   // a gap is only trusted when no divisor write fell inside it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         gapCnt <= 17'h00001;
         clean  <= 1'b0;
      end else begin
         gapCnt <= baudTick16 ? 17'h00001 : gapCnt + 17'h00001;
         clean  <= divWr ? 1'b0 : (baudTick16 ? 1'b1 : clean);
      end
   end
   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   AST_IDLE_ZERO: assert property (!ioRead |=> ioRdata == 8'h00)
      else $error("read data not zero while idle");
   AST_READ_HOLD: assert property (ioRead ##1 ioRead |=>
      $stable(ioRdata))
      else $error("read data changed during access");
   AST_ID_FIXED: assert property ($rose(ioRead) && idRd |=>
      ioRdata[7:6] == {2{$past(queueOnFlags)}} && ioRdata[5:4] == 2'b00)
      else $error("identify fixed bits wrong");
   AST_ID_CODE: assert property ($rose(ioRead) && idRd |=>
      (ioRdata[0] -> ioRdata[3:1] == 3'b000) &&
      (ioRdata[3] -> (ioRdata[2:1] == 2'b10 && $past(queueOnFlags))))
      else $error("identify code inconsistent");
   AST_EN_READ: assert property ($rose(ioRead) && !ioWrite &&
      !divisorSelect && ioAddr == OFS_ENABLE |=> ioRdata == {4'h0, enShadow})
      else $error("enable register read wrong");
   AST_DIV_READ: assert property ($rose(ioRead) && !ioWrite &&
      divisorSelect && ioAddr <= OFS_ENABLE |=>
      ioRdata == ($past(ioAddr[0]) ? divShadow[15:8] : divShadow[7:0]))
      else $error("divisor read wrong");
   AST_TX_ACCEPT: assert property (ioWrite &&
      !divisorSelect &&
      ioAddr == OFS_BYTE_PORT && txHoldFree && !txValid |=>
      txValid && txData == $past(ioWdata))
      else $error("written byte not offered to transmitter");
   AST_TX_HOLD: assert property (txValid && !txReady |=>
      txValid && $stable(txData))
      else $error("stalled transmit byte lost");
   AST_RX_TAKE: assert property (rxValid && rxReady |=> !rxReady)
      else $error("receive buffer took byte but stays ready");
   AST_EN_OFF: assert property (enWr && ioWdata[3:0] == 4'h0 |->
      ##2 !irqOut)
      else $error("interrupt with all sources disabled");
   AST_LINE_IRQ: assert property (lineErrEvent &&
      enShadow[EN_LINE_ERROR]
      && !enWr |-> ##2 irqOut)
      else $error("enabled line error did not interrupt");
   AST_BAUD_GAP: assert property (baudTick16 && clean |->
      gapCnt == {divShadow == 16'h0000, divShadow})
      else $error("baud tick spacing differs from divisor");
   cover property ($rose(ioRead) && idRd ##1 ioRdata[2:1] == 2'b11);
   cover property (txValid && !txReady ##1 !txHoldFree);
   cover property ($rose(irqOut));
endmodule
